/* logic/esmrd_defines.vh */
// Purpose: Constants for the extended SMRAM decode control block
// Assumes: Byte-wide configuration register at offset 9Eh
// Notes:   Included by the decode and register modules
`ifndef ESMRD_DEFINES_VH
`define ESMRD_DEFINES_VH

`define ESMRD_CTRL_OFFSET     8'h9E
`define ESMRD_CTRL_RESET      8'h38
`define ESMRD_BIT_HIGH_EN     7
`define ESMRD_BIT_ERR         6
`define ESMRD_BIT_CACHE       5
`define ESMRD_BIT_L1          4
`define ESMRD_BIT_L2          3
`define ESMRD_BIT_SZ_HI       2
`define ESMRD_BIT_SZ_LO       1
`define ESMRD_BIT_SEG_EN      0
`define ESMRD_HIGH_BASE       32'hFEDA0000
`define ESMRD_HIGH_LAST       32'hFEDBFFFF
`define ESMRD_LEGACY_BASE     32'h000A0000
`define ESMRD_WIN_MASK        32'h0001FFFF
`define ESMRD_SZ_1MB          2'h0
`define ESMRD_SZ_2MB          2'h1
`define ESMRD_SZ_8MB          2'h2
`define ESMRD_BYTES_1MB       32'h00100000
`define ESMRD_BYTES_2MB       32'h00200000
`define ESMRD_BYTES_8MB       32'h00800000
`define ESMRD_TOP_SHIFT       27

`endif

/* logic/esmrd_ctrl_reg.v */
// Purpose: Extended SMRAM control register with lock and error flag
// Assumes: Configuration writes are single-cycle byte strobes
// Notes:   Hardwired cache bits always read as one
`timescale 1ns/1ps
`default_nettype none
`include "esmrd_defines.vh"

module esmrd_ctrl_reg (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_wr,
    input  wire [7:0] i_wdata,
    input  wire       i_lock,
    input  wire       i_err_set,
    output wire [7:0] o_value
);
    reg       high_en_r;
    reg       err_r;
    reg [1:0] size_r;
    reg       seg_en_r;

    always @(posedge i_clk) begin
        if (i_rst) begin
            high_en_r <= 1'b0;
            err_r     <= 1'b0;
            size_r    <= 2'h0;
            seg_en_r  <= 1'b0;
        end else begin
            if (i_wr && !i_lock) begin // [R2]
                high_en_r <= i_wdata[`ESMRD_BIT_HIGH_EN];
                size_r    <= i_wdata[`ESMRD_BIT_SZ_HI:`ESMRD_BIT_SZ_LO];
                seg_en_r  <= i_wdata[`ESMRD_BIT_SEG_EN];
            end
            if (i_err_set)
                err_r <= 1'b1; // [R3] [R13]
            else if (i_wr && i_wdata[`ESMRD_BIT_ERR])
                err_r <= 1'b0; // [R4]
        end
    end

    assign o_value = {high_en_r, err_r, 3'h7, size_r, seg_en_r}; // [R5]
endmodule // esmrd_ctrl_reg
`default_nettype wire

/* logic/esmrd_decode.v */
// Purpose: Extended SMRAM decode: high window remap and top segment guard
// Assumes: One processor request per cycle, synchronous to i_clk
// Notes:   Decision registered one cycle after the request
//
// What this block does
// [R1] Both enables set: remap FEDA0000h-FEDBFFFFh onto A0000h-BFFFFh DRAM.
// [R2] Once locked, high enable, segment size and segment enable ignore writes.
// [R3] Non-SMM access to high window or top segment, not open, sets error flag.
// [R4] Error flag holds until software writes one to it.
// [R5] Bits 5, 4, 3 always read one, writes ignored.
// [R6] Size 00=1MB, 01=2MB, 10=8MB below top of low DRAM; 11 reserved.
// [R7] Top segment DRAM reachable only by SMM-tagged processor requests, or by any request while open and unlocked.
// [R8] Non-SMM requests into enabled top segment go to downstream link, except while open and unlocked.
// [R9] Top segment exists only when global enable and segment enable set.
// [R10] Global enable must be one for any extended function.
// [R11] Lock set by normal write, cleared only by reset, forces open low.
// [R12] Open and unlocked makes SMM DRAM visible without SMM decode.
// [R13] Hardware set of the error flag beats a same-cycle clear.
`timescale 1ns/1ps
`default_nettype none
`include "esmrd_defines.vh"

module esmrd_decode (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_cfg_wr,
    input  wire [7:0]  i_cfg_addr,
    input  wire [7:0]  i_cfg_wdata,
    input  wire        i_global_smram_enable,
    input  wire        i_smm_open_wr,
    input  wire        i_smm_open_wdata,
    input  wire        i_smm_lock_wr,
    input  wire [4:0]  i_top_low_usable_dram,
    input  wire        i_req_valid,
    input  wire [31:0] i_req_addr,
    input  wire        i_req_smm,
    output reg  [7:0]  o_cfg_rdata,
    output reg         o_smm_lock,
    output reg         o_smm_open,
    output reg         o_dram_valid,
    output reg  [31:0] o_dram_addr,
    output reg         o_link_valid,
    output reg  [31:0] o_link_addr
);
    // Route classes of one request, one-hot
    localparam [4:0] RT_HIGH_DRAM = 5'h01;
    localparam [4:0] RT_SEG_LINK  = 5'h02;
    localparam [4:0] RT_SEG_DRAM  = 5'h04;
    localparam [4:0] RT_LINK      = 5'h08;
    localparam [4:0] RT_DRAM      = 5'h10;

    // Control register and decode terms
    wire [7:0]  ctrl;
    wire        wr_hit;
    wire        rd_hit;
    wire        high_en;
    wire        seg_en;
    wire [1:0]  seg_size;
    wire        high_on;
    wire        seg_on;
    wire        in_high;
    wire        in_seg;
    wire        above_top;
    wire        smm_ok;
    wire        err_set;
    wire [31:0] top;
    wire [31:0] seg_base;
    wire [31:0] remap_addr;
    wire [7:0]  rdata_nxt;
    reg  [31:0] seg_bytes;
    reg  [4:0]  route_class;

    // Next values of the registered outputs
    reg         lock_nxt;
    reg         open_nxt;
    reg         dram_valid_nxt;
    reg  [31:0] dram_addr_nxt;
    reg         link_valid_nxt;
    reg  [31:0] link_addr_nxt;

    assign wr_hit = i_cfg_wr && (i_cfg_addr == `ESMRD_CTRL_OFFSET);
    assign rd_hit = (i_cfg_addr == `ESMRD_CTRL_OFFSET);

    esmrd_ctrl_reg u_reg (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_wr      (wr_hit),
        .i_wdata   (i_cfg_wdata),
        .i_lock    (o_smm_lock),
        .i_err_set (err_set),
        .o_value   (ctrl)
    );

    assign high_en  = ctrl[`ESMRD_BIT_HIGH_EN];
    assign seg_en   = ctrl[`ESMRD_BIT_SEG_EN];
    assign seg_size = ctrl[`ESMRD_BIT_SZ_HI:`ESMRD_BIT_SZ_LO];

    // Lock sets by a plain write; only reset clears it
    always @* begin
        lock_nxt = o_smm_lock;
        open_nxt = o_smm_open;
        if (i_smm_lock_wr) begin
            lock_nxt = 1'b1; // [R11]
        end
        if (i_smm_lock_wr || o_smm_lock) begin
            open_nxt = 1'b0; // [R11]
        end else if (i_smm_open_wr) begin
            open_nxt = i_smm_open_wdata;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_smm_lock <= 1'b0;
            o_smm_open <= 1'b0;
        end else begin
            o_smm_lock <= lock_nxt;
            o_smm_open <= open_nxt;
        end
    end

    always @* begin
        case (seg_size) // [R6]
            `ESMRD_SZ_1MB: seg_bytes = `ESMRD_BYTES_1MB;
            `ESMRD_SZ_2MB: seg_bytes = `ESMRD_BYTES_2MB;
            `ESMRD_SZ_8MB: seg_bytes = `ESMRD_BYTES_8MB;
            default:       seg_bytes = 32'h00000000;
        endcase
    end

    assign top        = {i_top_low_usable_dram, {`ESMRD_TOP_SHIFT{1'b0}}}; // [R6]
    assign seg_base   = top - seg_bytes; // [R6]
    assign high_on    = i_global_smram_enable && high_en; // [R1] [R10]
    assign seg_on     = i_global_smram_enable && seg_en; // [R9] [R10]
    assign in_high    = (i_req_addr >= `ESMRD_HIGH_BASE) && (i_req_addr <= `ESMRD_HIGH_LAST);
    assign in_seg     = (seg_bytes != 32'h00000000) && (i_req_addr < top)
                        && (i_req_addr >= seg_base); // [R6]
    assign above_top  = (i_req_addr >= top);
    assign remap_addr = `ESMRD_LEGACY_BASE | (i_req_addr & `ESMRD_WIN_MASK); // [R1]
    assign smm_ok     = i_req_smm || (o_smm_open && !o_smm_lock); // [R12]
    assign err_set    = i_req_valid && !i_req_smm && !o_smm_open
                        && ((high_on && in_high) || (seg_on && in_seg)); // [R3]

    // Classify the request
    always @* begin
        if (high_on && in_high && smm_ok) begin
            route_class = RT_HIGH_DRAM; // [R1] [R12]
        end else if (seg_on && in_seg && !smm_ok) begin
            route_class = RT_SEG_LINK; // [R7] [R8]
        end else if (seg_on && in_seg) begin
            route_class = RT_SEG_DRAM; // [R7]
        end else if (in_high || above_top) begin
            route_class = RT_LINK;
        end else begin
            route_class = RT_DRAM;
        end
    end

    // Route each request to DRAM or to the downstream link
    always @* begin
        dram_valid_nxt = 1'b0;
        dram_addr_nxt  = o_dram_addr;
        link_valid_nxt = 1'b0;
        link_addr_nxt  = o_link_addr;
        if (i_req_valid) begin
            case (route_class)
                RT_HIGH_DRAM: begin
                    dram_valid_nxt = 1'b1; // [R1]
                    dram_addr_nxt  = remap_addr;
                end
                RT_SEG_LINK: begin
                    link_valid_nxt = 1'b1; // [R8]
                    link_addr_nxt  = i_req_addr;
                end
                RT_SEG_DRAM: begin
                    dram_valid_nxt = 1'b1; // [R7]
                    dram_addr_nxt  = i_req_addr;
                end
                RT_LINK: begin
                    link_valid_nxt = 1'b1;
                    link_addr_nxt  = i_req_addr;
                end
                RT_DRAM: begin
                    dram_valid_nxt = 1'b1;
                    dram_addr_nxt  = i_req_addr;
                end
                default: begin
                    dram_valid_nxt = 1'b1;
                    dram_addr_nxt  = i_req_addr;
                end
            endcase
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_dram_valid <= 1'b0;
            o_dram_addr  <= 32'h00000000;
            o_link_valid <= 1'b0;
            o_link_addr  <= 32'h00000000;
        end else begin
            o_dram_valid <= dram_valid_nxt;
            o_dram_addr  <= dram_addr_nxt;
            o_link_valid <= link_valid_nxt;
            o_link_addr  <= link_addr_nxt;
        end
    end

    // Read-back data: register bits when addressed, zero elsewhere
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_rdata
            assign rdata_nxt[k] = rd_hit & ctrl[k]; // [R5]
        end
    endgenerate

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_cfg_rdata <= `ESMRD_CTRL_RESET;
        end else begin
            o_cfg_rdata <= rdata_nxt;
        end
    end
endmodule // esmrd_decode
`default_nettype wire

/* test/esmrd_props.sv */
// Purpose: Port checks for extended SMRAM decode
// Assumes: Bound to esmrd_decode, one clock
// Notes:   Top of low DRAM never zero in test
`timescale 1ns/1ps
`default_nettype none
module esmrd_props (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic        i_global_smram_enable,
    input wire logic        i_smm_lock_wr,
    input wire logic [4:0]  i_top_low_usable_dram,
    input wire logic        i_req_valid,
    input wire logic [31:0] i_req_addr,
    input wire logic        i_req_smm,
    input wire logic [7:0]  o_cfg_rdata,
    input wire logic        o_smm_lock,
    input wire logic        o_smm_open,
    input wire logic        o_dram_valid,
    input wire logic [31:0] o_dram_addr,
    input wire logic        o_link_valid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire [31:0] top = {i_top_low_usable_dram, 27'h0000000};
    wire win = i_req_addr[31:17] == 15'h7F6D;
    wire seg = i_req_addr < top && i_req_addr >= top - 32'h00100000;
    a_one_route: assert property (i_req_valid |=> o_dram_valid != o_link_valid)
        else $error("route count wrong");
    a_idle_quiet: assert property (!i_req_valid |=> !o_dram_valid && !o_link_valid)
        else $error("route without request");
    a_high_remap: assert property (i_req_valid && win |=>
        !o_dram_valid || o_dram_addr == {15'h0005, $past(i_req_addr[16:0])})
        else $error("high window remap wrong");
    a_no_global: assert property (i_req_valid && win && !i_global_smram_enable
        |=> o_link_valid) else $error("window used without global enable");
    a_seg_smm: assert property (i_req_valid && i_req_smm && seg |=>
        o_dram_valid && o_dram_addr == $past(i_req_addr)) else $error("segment smm miss");
    a_above_top: assert property (i_req_valid && !win && i_req_addr >= top
        |=> o_link_valid) else $error("above top not forwarded");
    a_lock_set: assert property (i_smm_lock_wr |=> o_smm_lock && !o_smm_open)
        else $error("lock set wrong");
    a_lock_hold: assert property (o_smm_lock |=> o_smm_lock)
        else $error("lock dropped");
    a_cache_ones: assert property (i_cfg_addr == 8'h9E |=> o_cfg_rdata[5:3] == 3'h7)
        else $error("cache bits not one");
endmodule // esmrd_props
bind esmrd_decode esmrd_props u_props (
    .i_clk                 (i_clk),
    .i_rst                 (i_rst),
    .i_cfg_addr            (i_cfg_addr),
    .i_global_smram_enable (i_global_smram_enable),
    .i_smm_lock_wr         (i_smm_lock_wr),
    .i_top_low_usable_dram (i_top_low_usable_dram),
    .i_req_valid           (i_req_valid),
    .i_req_addr            (i_req_addr),
    .i_req_smm             (i_req_smm),
    .o_cfg_rdata           (o_cfg_rdata),
    .o_smm_lock            (o_smm_lock),
    .o_smm_open            (o_smm_open),
    .o_dram_valid          (o_dram_valid),
    .o_dram_addr           (o_dram_addr),
    .o_link_valid          (o_link_valid)
);
`default_nettype wire

/* test/esmrd_host.sv */
// Purpose: Processor side issuing SMM tagged requests
// Assumes: Bench commands one request per cycle
// Notes:   Idle address and tag toggle, never hold old values
`timescale 1ns/1ps
`default_nettype none
module esmrd_host (
    input wire logic        i_clk,
    input wire logic        i_go,
    input wire logic [31:0] i_addr,
    input wire logic        i_smm,
    output var logic        o_valid,
    output var logic [31:0] o_addr,
    output var logic        o_smm
);
    always @(posedge i_clk) begin
        o_valid <= i_go;
        o_addr  <= i_go ? i_addr : ~o_addr;
        o_smm   <= i_go ? i_smm : ~o_smm;
    end
endmodule // esmrd_host
`default_nettype wire

/* test/extended_smram_decode_control_tb.sv */
// Purpose: Random bench with reference model of the decode
// Assumes: Seed 30, lock set once in each reset period
// Notes:   Outputs compared at every edge after the first
`timescale 1ns/1ps
`default_nettype none
module extended_smram_decode_control_tb;
    logic clk, rst = 1, cw = 0, ge = 1, ow = 0, od = 0, lw = 0, go = 0, gs = 0, arm = 0;
    logic [7:0] ca = 8'h9E, cd = 8'h00, rd, r = 8'h38;
    logic [4:0] tl = 5'h02;
    logic [31:0] ga = 32'h0, ra, da, la, e_a, top, sz;
    logic rv, rs, dv, lv, lk, op, win, seg, ok, hit;
    logic e_dv = 0, e_lv = 0, e_lk = 0, e_op = 0, lock = 0, open = 0;
    logic [7:0] e_rd = 8'h38;
    int errors = 0, checks = 0;
    esmrd_host u_host (.i_clk(clk), .i_go(go), .i_addr(ga), .i_smm(gs),
        .o_valid(rv), .o_addr(ra), .o_smm(rs));
    esmrd_decode DUT (.i_clk(clk), .i_rst(rst), .i_cfg_wr(cw), .i_cfg_addr(ca),
        .i_cfg_wdata(cd), .i_global_smram_enable(ge), .i_smm_open_wr(ow),
        .i_smm_open_wdata(od), .i_smm_lock_wr(lw), .i_top_low_usable_dram(tl),
        .i_req_valid(rv), .i_req_addr(ra), .i_req_smm(rs), .o_cfg_rdata(rd),
        .o_smm_lock(lk), .o_smm_open(op), .o_dram_valid(dv), .o_dram_addr(da),
        .o_link_valid(lv), .o_link_addr(la));
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (arm) begin
            chk("dram_valid", e_dv, dv);
            chk("link_valid", e_lv, lv);
            if (e_dv) chk("dram_addr", e_a, da);
            if (e_lv) chk("link_addr", e_a, la);
            chk("cfg_rdata", e_rd, rd);
            chk("lock", e_lk, lk);
            chk("open", e_op, op);
        end
        arm = 1;
        top = {tl, 27'h0000000};
        sz = r[2:1] == 2'h2 ? 32'h00800000 : r[2:1] == 2'h1 ? 32'h00200000 : 32'h00100000;
        win = ra[31:17] == 15'h7F6D;
        seg = ra < top && ra >= top - sz;
        ok = rs || (open && !lock);
        hit = rv && (win && ge && r[7] || seg && ge && r[0] && r[2:1] != 2'h3);
        e_dv = rv && (win ? ge && r[7] && ok : ra < top && !(hit && !ok));
        e_lv = rv && !e_dv;
        e_a = win && e_dv ? {15'h0005, ra[16:0]} : ra;
        e_rd = ca == 8'h9E ? r : 8'h00;
        if (cw && ca == 8'h9E) begin
            if (!lock) r = {cd[7], r[6], 3'h7, cd[2:0]};
            if (cd[6]) r[6] = 0;
        end
        if (hit && !rs && !open) r[6] = 1;
        if (lw) {lock, open} = 2'h2;
        else if (ow && !lock) open = od;
        if (rst) {r, lock, open, e_rd, e_dv, e_lv} = {8'h38, 2'h0, 8'h38, 2'h0};
        {e_lk, e_op} = {lock, open};
    end
    initial begin
        void'($urandom(30));
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 6000; i++) begin
            @(posedge clk);
            rst <= i >= 3000 && i < 3006;
            cw <= $urandom % 6 == 0;
            cd <= 8'($urandom);
            ca <= $urandom % 4 ? 8'h9E : 8'($urandom);
            ge <= $urandom % 8 != 0;
            ow <= $urandom % 16 == 0;
            od <= 1'($urandom);
            lw <= i % 3000 == 2000;
            go <= 1'($urandom);
            gs <= 1'($urandom);
            if (i % 500 == 0) tl <= 5'($urandom % 31 + 1);
            case ($urandom % 3)
                0: ga <= 32'hFEDA0000 | $urandom % 32'h00020000;
                1: ga <= {tl, 27'h0000000} - 1 - $urandom % 32'h00900000;
                default: ga <= $urandom;
            endcase
        end
        end_sim;
    end
endmodule // extended_smram_decode_control_tb
`default_nettype wire
